// *** rtl/rfv_top.sv ***
// Ring frequency validation with APB register access and interrupt.
// Assumes an APB master on pclk and an asynchronous ring detector input.
//
// Contract
// - A valid ring waits 0 to 1792 ms, set by a 3-bit delay select.
// - Each crossing loads the qualification timer with the load field.
// - A later crossing with timer above threshold invalidates the ring.
// - The timer steps down once per 2.0 ms tick.
// - The threshold sets the highest accepted ring frequency.
// - Validation runs only while the enable bit is set.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "rfv_defines.svh"
module rfv_top #(
	parameter int TICK_CYCLES = `RFV_TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ring_det_in,
	output logic ring_valid,
	output logic irq
);
	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [7:0] ctl1_q;
	logic [7:0] ctl2_q;
	logic [7:0] ctl3_q;
	logic [1:0] stat_q;
	logic [1:0] mask_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic ring_valid_q;
	logic irq_q;
	rfv_pkg::rfv_state_t state_q;
	logic [5:0] timer_q;
	logic [9:0] dly_cnt_q;
	rfv_pkg::rfv_cfg_t cfg;
	rfv_pkg::rfv_evt_t evt;
	logic crossing;
	logic tick;
	logic acc;
	logic wr;
	logic rd;
	logic [5:0] idx;
	logic mapped;
	logic too_fast;
	logic [9:0] dly_target;
	logic [31:0] rd_val;
	logic stat_rd;
	logic [1:0] stat_set;
	logic ring_over;
	logic dly_done;

	// ------------------------------------------------------------------
	// Register index match
	// ------------------------------------------------------------------
	function automatic logic hit(input logic [5:0] a, input logic [5:0] r);
		hit = (a == r);
	endfunction

	// ------------------------------------------------------------------
	// Leaf instances
	// ------------------------------------------------------------------
	rfv_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.ring_det_in(ring_det_in),
		.crossing(crossing)
	);

	rfv_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick)
	);

	// ------------------------------------------------------------------
	// Configuration view
	// ------------------------------------------------------------------
	assign cfg.en = ctl3_q[`RFV_CTL3_EN_BIT];
	assign cfg.delay_sel = {ctl2_q[`RFV_CTL2_DLY_HI_BIT],
		ctl1_q[`RFV_CTL1_DLY_LO_MSB:`RFV_CTL1_DLY_LO_LSB]};
	assign cfg.load = ctl3_q[`RFV_CTL3_LOAD_MSB:0];
	assign cfg.thresh = ctl1_q[`RFV_CTL1_THRESH_MSB:0];

	// ------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------
	assign idx = paddr[7:2];
	assign acc = psel && penable && pready_q;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;

	always_comb begin
		mapped = 1'b1;
		rd_val = 32'h0000_0000;
		if (paddr[1:0] != 2'b00) begin
			mapped = 1'b0;
		end else if (hit(idx, `RFV_IDX_CTL1)) begin
			rd_val = {24'h00_0000, ctl1_q};
		end else if (hit(idx, `RFV_IDX_CTL2)) begin
			rd_val = {24'h00_0000, ctl2_q};
		end else if (hit(idx, `RFV_IDX_CTL3)) begin
			rd_val = {24'h00_0000, ctl3_q};
		end else if (hit(idx, `RFV_IDX_IRQ_STAT)) begin
			rd_val = {30'h0000_0000, stat_q};
		end else if (hit(idx, `RFV_IDX_IRQ_MASK)) begin
			rd_val = {30'h0000_0000, mask_q};
		end else if (hit(idx, `RFV_IDX_STATE)) begin
			rd_val = {23'h00_0000, ring_valid_q, state_q, timer_q};
		end else begin
			mapped = 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// APB response
	// ------------------------------------------------------------------
	// One wait state: pready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= psel && penable && !pready_q;
			pslverr_q <= psel && penable && !pready_q && !mapped;
			if (psel && penable && !pready_q && !pwrite && mapped) begin
				prdata_q <= rd_val;
			end else begin
				prdata_q <= 32'h0000_0000;
			end
		end
	end

	// ------------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl1_q <= `RFV_CTL1_RESET;
			ctl2_q <= `RFV_CTL2_RESET;
			ctl3_q <= `RFV_CTL3_RESET;
			mask_q <= 2'b00;
		end else if (wr && paddr[1:0] == 2'b00) begin
			if (hit(idx, `RFV_IDX_CTL1)) begin
				ctl1_q <= pwdata[7:0];
			end else if (hit(idx, `RFV_IDX_CTL2)) begin
				ctl2_q <= {pwdata[7], 7'h00};
			end else if (hit(idx, `RFV_IDX_CTL3)) begin
				ctl3_q <= {pwdata[7], 1'b0, pwdata[5:0]};
			end else if (hit(idx, `RFV_IDX_IRQ_MASK)) begin
				mask_q <= pwdata[1:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// Qualification
	// ------------------------------------------------------------------
	assign too_fast = timer_q > cfg.thresh;
	assign dly_target = {cfg.delay_sel, 7'h00};
	assign ring_over = !crossing && tick && timer_q == 6'h00;
	assign dly_done = dly_cnt_q >= dly_target;

	// ------------------------------------------------------------------
	// Qualification timer
	// ------------------------------------------------------------------
	// Timer reload on every crossing, step down per tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_q <= 6'h00;
		end else if (!cfg.en) begin
			timer_q <= 6'h00;
		end else if (crossing) begin
			timer_q <= cfg.load;
		end else if (tick && timer_q != 6'h00) begin
			timer_q <= timer_q - 6'h01;
		end
	end

	// ------------------------------------------------------------------
	// Qualification state machine
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= rfv_pkg::RFV_IDLE;
		end else if (!cfg.en) begin
			state_q <= rfv_pkg::RFV_IDLE;
		end else begin
			case (state_q)
				rfv_pkg::RFV_IDLE: begin
					if (crossing) begin
						state_q <= rfv_pkg::RFV_QUAL;
					end
				end
				rfv_pkg::RFV_QUAL: begin
					if (crossing && !too_fast) begin
						state_q <= rfv_pkg::RFV_DELAY;
					end else if (ring_over) begin
						state_q <= rfv_pkg::RFV_IDLE;
					end
				end
				rfv_pkg::RFV_DELAY: begin
					if (crossing && too_fast) begin
						state_q <= rfv_pkg::RFV_QUAL;
					end else if (ring_over) begin
						state_q <= rfv_pkg::RFV_IDLE;
					end else if (dly_done) begin
						state_q <= rfv_pkg::RFV_VALID;
					end
				end
				default: begin
					if (crossing && too_fast) begin
						state_q <= rfv_pkg::RFV_QUAL;
					end else if (ring_over) begin
						state_q <= rfv_pkg::RFV_IDLE;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Delay counter
	// ------------------------------------------------------------------
	// Delay counter runs in ticks only while waiting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dly_cnt_q <= 10'h000;
		end else if (state_q != rfv_pkg::RFV_DELAY) begin
			dly_cnt_q <= 10'h000;
		end else if (tick && dly_cnt_q < dly_target) begin
			dly_cnt_q <= dly_cnt_q + 10'h001;
		end
	end

	// ------------------------------------------------------------------
	// Events
	// ------------------------------------------------------------------
	assign evt.valid_set = cfg.en && state_q == rfv_pkg::RFV_DELAY &&
		!(crossing && too_fast) &&
		!ring_over &&
		dly_done;
	assign evt.invalid_set = cfg.en && crossing && too_fast &&
		state_q != rfv_pkg::RFV_IDLE;

	// ------------------------------------------------------------------
	// Indication
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ring_valid_q <= 1'b0;
		end else begin
			ring_valid_q <= (state_q == rfv_pkg::RFV_VALID) && cfg.en;
		end
	end

	// ------------------------------------------------------------------
	// Status and interrupt
	// ------------------------------------------------------------------
	// Read clears status; a new event in the same cycle wins
	assign stat_rd = rd && paddr[1:0] == 2'b00 &&
		hit(idx, `RFV_IDX_IRQ_STAT);
	assign stat_set = {evt.invalid_set, evt.valid_set};

	for (genvar i = 0; i < 2; i++) begin : g_stat
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				stat_q[i] <= 1'b0;
			end else if (stat_set[i]) begin
				stat_q[i] <= 1'b1;
			end else if (stat_rd) begin
				stat_q[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(stat_q & mask_q);
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign ring_valid = ring_valid_q;
	assign irq = irq_q;
endmodule // rfv_top

// *** rtl/rfv_defines.svh ***
// Ring validation constants: register indices, fields, resets, timing.
// Assumes a 20 MHz pclk; included by rfv_top and the bench.
`ifndef RFV_DEFINES_SVH
`define RFV_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define RFV_IDX_CTL1 6'h16
`define RFV_IDX_CTL2 6'h17
`define RFV_IDX_CTL3 6'h18
`define RFV_IDX_IRQ_STAT 6'h20
`define RFV_IDX_IRQ_MASK 6'h21
`define RFV_IDX_STATE 6'h22

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RFV_CTL1_DLY_LO_MSB 7
`define RFV_CTL1_DLY_LO_LSB 6
`define RFV_CTL1_THRESH_MSB 5
`define RFV_CTL2_DLY_HI_BIT 7
`define RFV_CTL3_EN_BIT 7
`define RFV_CTL3_LOAD_MSB 5
`define RFV_IRQ_VALID_BIT 0
`define RFV_IRQ_INVALID_BIT 1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RFV_CTL1_RESET 8'h96
`define RFV_CTL2_RESET 8'h00
`define RFV_CTL3_RESET 8'h19

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RFV_CLK_PERIOD_NS 50
`define RFV_TICK_US 2000
`define RFV_TICK_CYCLES ((`RFV_TICK_US * 1000) / `RFV_CLK_PERIOD_NS)
`define RFV_DELAY_STEP_MS 256
`define RFV_DELAY_STEP_TICKS ((`RFV_DELAY_STEP_MS * 1000) / `RFV_TICK_US)

`endif

// *** rtl/rfv_pkg.sv ***
// Types shared by the ring validation modules.
// Constants live in rfv_defines.svh.
package rfv_pkg;

	typedef enum logic [1:0] {
		RFV_IDLE = 2'b00,
		RFV_QUAL = 2'b01,
		RFV_DELAY = 2'b10,
		RFV_VALID = 2'b11
	} rfv_state_t;

	typedef struct packed {
		logic en;
		logic [2:0] delay_sel;
		logic [5:0] load;
		logic [5:0] thresh;
	} rfv_cfg_t;

	typedef struct packed {
		logic valid_set;
		logic invalid_set;
	} rfv_evt_t;

endpackage

// *** rtl/rfv_sync.sv ***
// Three-flop synchroniser and rising-edge detector for the ring detector.
// Assumes ring_det_in is asynchronous to pclk.
`timescale 1ns/100ps
module rfv_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ring_det_in,
	output logic crossing
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic level_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= ring_det_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Level changes only once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_q <= 1'b0;
		end else if (s2_q == s3_q) begin
			level_q <= s3_q;
		end
	end

	assign crossing = (s2_q == s3_q) && s3_q && !level_q;
endmodule // rfv_sync

// *** rtl/rfv_tick.sv ***
// Free-running divider giving a one-cycle pulse every TICK_CYCLES clocks.
// Assumes TICK_CYCLES of at least two.
`timescale 1ns/100ps
module rfv_tick #(
	parameter int TICK_CYCLES = 40000
) (
	input wire logic pclk,
	input wire logic presetn,
	output logic tick
);
	logic [15:0] cnt_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 16'h0000;
		end else if (cnt_q == 16'(TICK_CYCLES - 1)) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	assign tick = (cnt_q == 16'(TICK_CYCLES - 1));
endmodule // rfv_tick

// *** dv/rfv_ring_src.sv ***
// Ring threshold detector model: periodic crossings while on.
// Assumes period of at least two pclk cycles; line idles low when off.
`timescale 1ns/100ps
module rfv_ring_src (
	input wire logic pclk,
	input wire logic on,
	input wire logic [15:0] period,
	output logic ring_det_in
);
	logic [15:0] cnt_q = 16'h0000;
	always @(posedge pclk) begin
		cnt_q <= (!on || cnt_q >= period - 1) ? 16'h0000 : cnt_q + 1;
		ring_det_in <= on && (cnt_q < period / 2);
	end
endmodule // rfv_ring_src

// *** dv/rfv_top_assertions.sv ***
// Checker for the ring validation block: APB timing and outputs.
// Assumes binding to rfv_top with pclk and active-low presetn.
`timescale 1ns/100ps
module rfv_top_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ring_valid,
	input wire logic irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_first_access;
		psel && penable && !$past(penable);
	endsequence
	sequence s_one_wait;
		!pready ##1 pready;
	endsequence
	a_ready_wait: assert property (s_first_access |-> s_one_wait)
		else $error("pready not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	a_ready_setup: assert property (psel && !penable |-> !pready)
		else $error("pready in setup phase");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("prdata not zero outside answer");
	a_rdata_write: assert property (pready && pwrite |-> prdata == 0)
		else $error("prdata not zero on write");
	a_rdata_byte: assert property (prdata[31:9] == 23'h00_0000)
		else $error("prdata upper bits set");
	a_reset_quiet: assert property ($rose(presetn) |-> !ring_valid && !irq)
		else $error("outputs active after reset");
endmodule // rfv_top_checker
bind rfv_top rfv_top_checker rfv_top_checker_inst (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.ring_valid(ring_valid), .irq(irq));

// *** dv/rfv_top_test.sv ***
// Self-checking bench for ring validation over APB.
// Assumes TICK_CYCLES of 8, so one delay step is 1024 cycles.
`timescale 1ns/100ps
`include "rfv_defines.svh"
module rfv_top_test;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic pready, pslverr, ring_det_in, ring_valid, irq, on = 0;
	logic [15:0] period = 16'h0078;
	int mismatches = 0, checks = 0, cyc = 0;
	always #25 pclk = ~pclk;
	rfv_top #(.TICK_CYCLES(8)) rfv_top_inst (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ring_det_in(ring_det_in), .ring_valid(ring_valid), .irq(irq));
	rfv_ring_src rfv_ring_src_inst (.pclk(pclk), .on(on),
		.period(period), .ring_det_in(ring_det_in));
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			mismatches++;
			end_of_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// APB transfer; holds the request until pready
	task automatic acc(input logic w, input logic [5:0] idx,
		input logic [31:0] d, input logic [31:0] e, input logic ee);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		if (!w)
			chk(prdata, e);
		chk(pslverr, ee);
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		acc(1, idx, {24'h00_0000, d}, 0, 0);
	endtask
	task automatic ring(input logic o, input logic [15:0] p);
		@(posedge pclk);
		on <= o;
		period <= p;
	endtask
	task automatic hold(input int n);
		logic seen;
		seen = 0;
		repeat (n) begin
			@(negedge pclk);
			seen = seen | ring_valid;
		end
		chk(seen, 0);
	endtask
	task automatic until_v(input int n);
		repeat (n) if (ring_valid !== 1'b1) @(negedge pclk);
		chk(ring_valid, 1);
	endtask
	task automatic stop_ring;
		ring(0, 16'h0078);
		repeat (300) @(posedge pclk);
	endtask
	task automatic t_regs;
		acc(0, `RFV_IDX_CTL1, 0, 32'h0000_0096, 0);
		acc(0, `RFV_IDX_CTL2, 0, 32'h0000_0000, 0);
		acc(0, `RFV_IDX_CTL3, 0, 32'h0000_0019, 0);
		acc(0, 6'h3F, 0, 32'h0000_0000, 1);
		acc(0, `RFV_IDX_IRQ_MASK, 0, 32'h0000_0000, 0);
		acc(0, `RFV_IDX_STATE, 0, 32'h0000_0000, 0);
	endtask
	task automatic t_good;
		wr(`RFV_IDX_CTL1, 8'h0A);
		wr(`RFV_IDX_CTL3, 8'h94);
		acc(0, `RFV_IDX_CTL3, 0, 32'h0000_0094, 0);
		wr(`RFV_IDX_IRQ_MASK, 8'h01);
		ring(1, 16'h0078);
		until_v(600);
		repeat (2) @(negedge pclk);
		chk(irq, 1);
		acc(0, `RFV_IDX_IRQ_STAT, 0, 32'h0000_0001, 0);
		repeat (2) @(negedge pclk);
		chk(irq, 0);
		stop_ring();
		chk(ring_valid, 0);
	endtask
	task automatic t_fast;
		wr(`RFV_IDX_IRQ_MASK, 8'h02);
		ring(1, 16'h0028);
		hold(400);
		chk(irq, 1);
		stop_ring();
		acc(0, `RFV_IDX_IRQ_STAT, 0, 32'h0000_0002, 0);
	endtask
	task automatic t_delay(input logic [2:0] s);
		wr(`RFV_IDX_CTL2, {s[2], 7'h00});
		acc(0, `RFV_IDX_CTL2, 0, {24'h00_0000, s[2], 7'h00}, 0);
		wr(`RFV_IDX_CTL1, {s[1:0], 6'h0A});
		ring(1, 16'h0078);
		hold(s * 1024);
		until_v(400);
		stop_ring();
		acc(0, `RFV_IDX_IRQ_STAT, 0, 32'h0000_0001, 0);
	endtask
	task automatic t_cancel;
		wr(`RFV_IDX_CTL2, 8'h00);
		wr(`RFV_IDX_CTL1, 8'h4A);
		wr(`RFV_IDX_IRQ_MASK, 8'h01);
		ring(1, 16'h0078);
		repeat (400) @(posedge pclk);
		ring(1, 16'h0028);
		hold(1400);
		chk(irq, 0);
		stop_ring();
		acc(0, `RFV_IDX_IRQ_STAT, 0, 32'h0000_0002, 0);
	endtask
	task automatic t_off;
		wr(`RFV_IDX_CTL1, 8'h0A);
		wr(`RFV_IDX_CTL3, 8'h14);
		ring(1, 16'h0078);
		hold(800);
		acc(0, `RFV_IDX_STATE, 0, 32'h0000_0000, 0);
		stop_ring();
		acc(0, `RFV_IDX_IRQ_STAT, 0, 32'h0000_0000, 0);
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		t_regs();
		t_good();
		t_fast();
		t_delay(3'h1);
		t_delay(3'h7);
		t_cancel();
		t_off();
		end_of_test();
	end
endmodule // rfv_top_test
